// ### logic/fdc_status_params.svh
/*
 holds field positions, used bit masks, reset values and the result byte count for the result status block.
 assumes inclusion by its bare name from the design files.
*/
`ifndef FDC_STATUS_PARAMS_SVH
`define FDC_STATUS_PARAMS_SVH

// second result byte bit positions
`define ST2_END_OF_TRACK 7
`define ST2_CRC_ANY 5
`define ST2_OVERRUN 4
`define ST2_SECTOR_ABSENT 2
`define ST2_WRITE_PROT 1
`define ST2_SYNC_ABSENT 0
// third result byte bit positions
`define ST3_DELETED 6
`define ST3_PAYLOAD_CRC 5
`define ST3_TRACK_MISMATCH 4
`define ST3_BAD_TRACK 1
`define ST3_PAYLOAD_SYNC 0
// fourth result byte bit positions
`define ST4_WRITE_LOCK 6
`define ST4_ONE_HI 5
`define ST4_TRACK_ZERO 4
`define ST4_ONE_LO 3
`define ST4_HEAD 2
`define ST4_UNIT_HI 1
`define ST4_UNIT_LO 0
// bad track value in an identifier
`define BAD_TRACK_VALUE 8'hff
// bits that may ever read one in the second and third result bytes
`define ST2_USED_MASK 8'hb7
`define ST3_USED_MASK 8'h73
// number of result bytes presented in this block
`define RESULT_BYTES 3
// drive output register reset bit and rate select reset bit positions
`define DRIVE_OUT_RESET_BIT 2
`define RATE_RESET_BIT 7
// reset values
`define SPECIFY_RESET 8'h00
`define POLL_ENABLE_RESET 1'b1

`endif

// ### logic/fdc_status_pkg.sv
/*
 holds the types for the result status block.
 assumes the params header is on the include path.
*/
package fdc_status_pkg;

   // events reported by the command sequencer, one pulse per event
   typedef struct packed {
      logic end_of_track;
      logic no_terminal_count;
      logic id_crc_fault;
      logic data_crc_fault;
      logic overrun;
      logic sector_absent;
      logic read_id_error;
      logic track_sequence_error;
      logic id_mark_absent;
      logic data_mark_absent;
      logic deleted_mismatch;
      logic id_track_check;
   } fdc_event_t;

   // command class active during execution
   typedef struct packed {
      logic writing;
      logic reading;
   } cmd_class_t;

   typedef enum logic [1:0] {
      CORE_RESET,
      CORE_IDLE,
      CORE_BUSY,
      CORE_RESULT
   } core_state_t;

endpackage

// ### logic/result_shift.sv
/*
 holds the result byte presenter: loads three status bytes and hands them out
 one per data register read.
 assumes reads arrive as single-cycle pulses on the system clock.
*/
`include "fdc_status_params.svh"
module result_shift (
   input wire logic clk_i,
   input wire logic clear_i,
   input wire logic load_i,
   input wire logic [7:0] byte0_i,
   input wire logic [7:0] byte1_i,
   input wire logic [7:0] byte2_i,
   input wire logic read_i,
   output logic [7:0] data_o,
   output logic active_o
);
   logic [7:0] mem_q [`RESULT_BYTES];
   logic [1:0] idx_q;
   logic active_q;

   always_ff @(posedge clk_i) begin
      if (clear_i) begin
         active_q <= 1'b0;
         idx_q <= 2'h0;
      end else if (load_i) begin
         active_q <= 1'b1;
         idx_q <= 2'h0;
      end else if (read_i && active_q) begin
         if (idx_q == 2'(`RESULT_BYTES - 1)) begin
            active_q <= 1'b0;
            idx_q <= 2'h0;
         end else begin
            idx_q <= idx_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (clear_i) begin
         mem_q[0] <= 8'h00;
         mem_q[1] <= 8'h00;
         mem_q[2] <= 8'h00;
      end else if (load_i) begin
         mem_q[0] <= byte0_i;
         mem_q[1] <= byte1_i;
         mem_q[2] <= byte2_i;
      end
   end

   assign data_o = active_q ? mem_q[idx_q] : 8'h00;
   assign active_o = active_q;
endmodule // result_shift

// ### logic/fdc_result_status.sv
/*
 holds the result status and reset block of the floppy controller core: builds the
 second, third and fourth result bytes, presents them through the data register,
 and manages the pin, drive output and rate select resets.
 assumes the command sequencer and drive pins sit outside; pins pass a two flop sync.
*/
// Functional notes
// - set end of track past last sector
// - fixed zero bits in second, third bytes
// - crc fault on id or data
// - overrun or underrun flag
// - sector absent on read failures
// - write protect high during write commands
// - missing identifier or data mark
// - deleted mark mismatch flag
// - data field crc fault
// - identifier track differs from internal track
// - mismatched track equals ff marks bad
// - no data or deleted mark
// - fourth byte reports drive pin levels
// - fourth byte bits 5,3 read one
// - pin, drive output, rate resets, power on
// - any reset leaves power down
// - pin reset aborts all, goes idle
// - leaving reset clears registers and configure
// - polling starts after reset unless disabled
// - pin reset keeps specify values
// - pin reset sets drive output reset bit
// - rate reset self clears, drive output wins
// - result bytes read out in turn
`include "fdc_status_params.svh"
module fdc_result_status (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic system_reset_pin_n_i,
   input wire logic drive_output_reg_write_i,
   input wire logic [7:0] drive_output_reg_data_i,
   input wire logic rate_write_i,
   input wire logic [7:0] rate_data_i,
   input wire logic specify_write_i,
   input wire logic [7:0] specify_data_i,
   input wire logic configure_write_i,
   input wire logic configure_poll_off_i,
   input wire logic powerdown_req_i,
   input wire logic cmd_start_i,
   input wire fdc_status_pkg::cmd_class_t cmd_class_i,
   input wire fdc_status_pkg::fdc_event_t event_i,
   input wire logic [7:0] id_track_i,
   input wire logic [7:0] internal_track_i,
   input wire logic cmd_done_i,
   input wire logic data_read_i,
   input wire logic write_lock_pin_i,
   input wire logic track_zero_pin_i,
   input wire logic head_pick_pin_i,
   input wire logic [1:0] unit_select_pin_i,
   output logic [7:0] result_data_o,
   output logic result_phase_o,
   output logic core_reset_o,
   output logic powered_down_o,
   output logic poll_enable_o,
   output logic busy_o,
   output logic drive_output_reg_reset_o,
   output logic [7:0] specify_o
);
   logic [1:0] pin_rst_sync_q;
   logic [1:0] wp_sync_q;
   logic [1:0] track_zero_sync_q;
   logic [1:0] head_sync_q;
   logic [3:0] unit_sync_q;
   logic hw_reset;
   logic drive_out_reset_q;
   logic rate_reset_q;
   logic soft_reset;
   logic any_reset;
   logic core_reset_q;
   logic busy_q;
   logic cmd_take;
   logic result_load;
   fdc_status_pkg::core_state_t state_q;
   fdc_status_pkg::cmd_class_t class_q;
   logic [7:0] st2_q;
   logic [7:0] st3_q;
   logic [7:0] st4;
   logic [7:0] specify_q;
   logic poll_q;
   logic down_q;
   logic [7:0] shift_data;
   logic shift_active;
   logic [7:0] result_q;
   logic phase_q;

   // compares the sequencer state, shared by the take, load and sleep decodes
   function automatic logic state_is(input fdc_status_pkg::core_state_t cur,
      input fdc_status_pkg::core_state_t want);
      return cur == want;
   endfunction

   // pin inputs go through two flops; the pin is active low
   always_ff @(posedge clk_i) begin
      pin_rst_sync_q <= {pin_rst_sync_q[0], system_reset_pin_n_i};
      wp_sync_q <= {wp_sync_q[0], write_lock_pin_i};
      track_zero_sync_q <= {track_zero_sync_q[0], track_zero_pin_i};
      head_sync_q <= {head_sync_q[0], head_pick_pin_i};
      unit_sync_q <= {unit_sync_q[1:0], unit_select_pin_i};
   end

   // power on reset acts as the pin reset, and also clears the specify values
   assign hw_reset = rst_i | ~pin_rst_sync_q[1];
   assign soft_reset = drive_out_reset_q | rate_reset_q;
   assign any_reset = hw_reset | soft_reset;

   // drive output reset bit: set by pin reset, held until host clears
   always_ff @(posedge clk_i) begin
      if (hw_reset) begin
         drive_out_reset_q <= 1'b1;
      end else if (drive_output_reg_write_i) begin
         drive_out_reset_q <= drive_output_reg_data_i[`DRIVE_OUT_RESET_BIT];
      end
   end

   // rate select reset bit clears itself one cycle after a write
   always_ff @(posedge clk_i) begin
      if (hw_reset || drive_out_reset_q) begin
         rate_reset_q <= 1'b0;
      end else if (rate_write_i) begin
         rate_reset_q <= rate_data_i[`RATE_RESET_BIT];
      end else begin
         rate_reset_q <= 1'b0;
      end
   end

   // specify values survive the pin reset and every soft reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         specify_q <= `SPECIFY_RESET;
      end else if (specify_write_i && !any_reset) begin
         specify_q <= specify_data_i;
      end
   end

   // configure information is cleared by any reset; polling resumes
   always_ff @(posedge clk_i) begin
      if (any_reset) begin
         poll_q <= `POLL_ENABLE_RESET;
      end else if (configure_write_i) begin
         poll_q <= ~configure_poll_off_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (any_reset) begin
         down_q <= 1'b0;
      end else if (powerdown_req_i && state_is(state_q, fdc_status_pkg::CORE_IDLE)) begin
         down_q <= 1'b1;
      end else if (cmd_start_i) begin
         down_q <= 1'b0;
      end
   end

   // command sequencing: reset aborts everything and returns idle
   always_ff @(posedge clk_i) begin
      if (any_reset) begin
         state_q <= fdc_status_pkg::CORE_RESET;
         class_q <= '0;
      end else begin
         case (state_q)
            fdc_status_pkg::CORE_RESET: begin
               state_q <= fdc_status_pkg::CORE_IDLE;
            end
            fdc_status_pkg::CORE_IDLE: begin
               if (cmd_start_i) begin
                  state_q <= fdc_status_pkg::CORE_BUSY;
                  class_q <= cmd_class_i;
               end
            end
            fdc_status_pkg::CORE_BUSY: begin
               if (cmd_done_i) begin
                  state_q <= fdc_status_pkg::CORE_RESULT;
               end
            end
            fdc_status_pkg::CORE_RESULT: begin
               if (!shift_active && !cmd_done_i) begin
                  state_q <= fdc_status_pkg::CORE_IDLE;
               end
            end
            default: begin
               state_q <= fdc_status_pkg::CORE_IDLE;
            end
         endcase
      end
   end

   // a command is taken only from idle; result bytes load as execution ends
   assign cmd_take = cmd_start_i && state_is(state_q, fdc_status_pkg::CORE_IDLE);
   assign result_load = cmd_done_i && state_is(state_q, fdc_status_pkg::CORE_BUSY);

   // reset flag tracks the reset state so the output needs no decode
   always_ff @(posedge clk_i) begin
      core_reset_q <= any_reset;
   end

   // busy follows the sequencer: set on a taken command, dropped at done or reset
   always_ff @(posedge clk_i) begin
      if (any_reset) begin
         busy_q <= 1'b0;
      end else if (cmd_take) begin
         busy_q <= 1'b1;
      end else if (busy_q && cmd_done_i) begin
         busy_q <= 1'b0;
      end
   end

   // second result byte, sticky over one command
   always_ff @(posedge clk_i) begin
      if (any_reset || cmd_take) begin
         st2_q <= 8'h00;
      end else if (state_q == fdc_status_pkg::CORE_BUSY) begin
         if (event_i.end_of_track || event_i.no_terminal_count) begin
            st2_q[`ST2_END_OF_TRACK] <= 1'b1;
         end
         if (event_i.id_crc_fault || event_i.data_crc_fault) begin
            st2_q[`ST2_CRC_ANY] <= 1'b1;
         end
         if (event_i.overrun) begin
            st2_q[`ST2_OVERRUN] <= 1'b1;
         end
         if (event_i.sector_absent || event_i.read_id_error || event_i.track_sequence_error) begin
            st2_q[`ST2_SECTOR_ABSENT] <= 1'b1;
         end
         if (class_q.writing && wp_sync_q[1]) begin
            st2_q[`ST2_WRITE_PROT] <= 1'b1;
         end
         if (event_i.id_mark_absent || event_i.data_mark_absent) begin
            st2_q[`ST2_SYNC_ABSENT] <= 1'b1;
         end
      end
   end

   // third result byte, sticky over one command
   always_ff @(posedge clk_i) begin
      if (any_reset || cmd_take) begin
         st3_q <= 8'h00;
      end else if (state_q == fdc_status_pkg::CORE_BUSY) begin
         if (event_i.deleted_mismatch) begin
            st3_q[`ST3_DELETED] <= 1'b1;
         end
         if (event_i.data_crc_fault) begin
            st3_q[`ST3_PAYLOAD_CRC] <= 1'b1;
         end
         if (event_i.id_track_check && id_track_i != internal_track_i) begin
            st3_q[`ST3_TRACK_MISMATCH] <= 1'b1;
            if (id_track_i == `BAD_TRACK_VALUE) begin
               st3_q[`ST3_BAD_TRACK] <= 1'b1;
            end
         end
         if (event_i.data_mark_absent) begin
            st3_q[`ST3_PAYLOAD_SYNC] <= 1'b1;
         end
      end
   end

   // fourth result byte mirrors drive pins, with fixed ones
   always_comb begin
      st4 = 8'h00;
      st4[`ST4_WRITE_LOCK] = wp_sync_q[1];
      st4[`ST4_TRACK_ZERO] = track_zero_sync_q[1];
      st4[`ST4_HEAD] = head_sync_q[1];
      st4[`ST4_UNIT_HI] = unit_sync_q[3];
      st4[`ST4_UNIT_LO] = unit_sync_q[2];
      st4[`ST4_ONE_HI] = 1'b1;
      st4[`ST4_ONE_LO] = 1'b1;
   end

   // unused bits of second and third bytes are masked to zero
   result_shift shifter (
      .clk_i(clk_i),
      .clear_i(any_reset),
      .load_i(result_load),
      .byte0_i(st2_q & `ST2_USED_MASK),
      .byte1_i(st3_q & `ST3_USED_MASK),
      .byte2_i(st4),
      .read_i(data_read_i),
      .data_o(shift_data),
      .active_o(shift_active)
   );

   always_ff @(posedge clk_i) begin
      if (any_reset) begin
         result_q <= 8'h00;
         phase_q <= 1'b0;
      end else begin
         result_q <= shift_data;
         phase_q <= shift_active;
      end
   end

   assign result_data_o = result_q;
   assign result_phase_o = phase_q;
   assign core_reset_o = core_reset_q;
   assign powered_down_o = down_q;
   assign poll_enable_o = poll_q;
   assign busy_o = busy_q;
   assign drive_output_reg_reset_o = drive_out_reset_q;
   assign specify_o = specify_q;
endmodule // fdc_result_status

// ### dv/fdc_status_monitor.sv
/*
 checker for the result status block: reset sources, specify retention, command take.
 assumes it is bound onto fdc_result_status and sees only its ports.
*/
module fdc_status_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic system_reset_pin_n_i,
   input wire logic drive_output_reg_write_i,
   input wire logic [7:0] drive_output_reg_data_i,
   input wire logic rate_write_i,
   input wire logic [7:0] rate_data_i,
   input wire logic specify_write_i,
   input wire logic cmd_start_i,
   input wire logic [7:0] result_data_o,
   input wire logic result_phase_o,
   input wire logic core_reset_o,
   input wire logic powered_down_o,
   input wire logic poll_enable_o,
   input wire logic busy_o,
   input wire logic drive_output_reg_reset_o,
   input wire logic [7:0] specify_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   pin_reset_a: assert property (
      !system_reset_pin_n_i [*4]
      |-> drive_output_reg_reset_o && !busy_o && !powered_down_o)
      else $error("pin reset left the core running");
   reset_hold_a: assert property (
      drive_output_reg_reset_o && !drive_output_reg_write_i |=> drive_output_reg_reset_o)
      else $error("drive output reset bit cleared itself");
   reset_wins_a: assert property (
      drive_output_reg_reset_o |=> core_reset_o)
      else $error("core left reset while drive output reset set");
   reset_enter_a: assert property (
      drive_output_reg_write_i && drive_output_reg_data_i[2]
      |=> ##[0:1] core_reset_o && !busy_o)
      else $error("drive output reset write not taken");
   rate_clear_a: assert property (
      rate_write_i && rate_data_i[7] && !drive_output_reg_reset_o
      |=> !drive_output_reg_reset_o ##[0:2] core_reset_o ##[1:4] !core_reset_o)
      else $error("rate reset did not pulse and clear");
   wake_up_a: assert property (
      core_reset_o |=> !powered_down_o)
      else $error("power down kept through reset");
   poll_on_a: assert property (
      $fell(core_reset_o) |-> ##[0:1] poll_enable_o)
      else $error("polling off after leaving reset");
   spec_keep_a: assert property (
      !specify_write_i |=> $stable(specify_o))
      else $error("specify values changed without a write");
   start_take_a: assert property (
      cmd_start_i && !busy_o && !core_reset_o && !result_phase_o && !powered_down_o
      && !drive_output_reg_reset_o |=> busy_o)
      else $error("idle core refused a command");
   result_idle_a: assert property (
      !result_phase_o |-> result_data_o == 8'h00)
      else $error("result data outside result phase");
endmodule // fdc_status_monitor

bind fdc_result_status fdc_status_monitor fdc_status_monitor_inst (.*);

// ### dv/drive_cable_model.sv
/*
 drive side of the cable: presents write lock, track zero, head and unit pins.
 assumes the bench sets the wanted levels; pins follow one clock later.
*/
module drive_cable_model (
   input wire logic clk_i,
   input wire logic [4:0] levels_i,
   output logic write_lock_pin_o,
   output logic track_zero_pin_o,
   output logic head_pick_pin_o,
   output logic [1:0] unit_select_pin_o
);
   always_ff @(posedge clk_i) begin
      write_lock_pin_o <= levels_i[4];
      track_zero_pin_o <= levels_i[3];
      head_pick_pin_o <= levels_i[2];
      unit_select_pin_o <= levels_i[1:0];
   end
endmodule // drive_cable_model

// ### dv/tb_top.sv
/*
 self-checking bench for the result status and reset block.
 assumes the design package and the cable model are compiled first.
*/
`define CHK(n, e, a) \
   begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'h0, rst_i = 1'h1, system_reset_pin_n_i = 1'h1;
   logic drive_output_reg_write_i = 1'h0;
   logic rate_write_i = 1'h0, specify_write_i = 1'h0, configure_write_i = 1'h0;
   logic configure_poll_off_i = 1'h0, powerdown_req_i = 1'h0, cmd_start_i = 1'h0;
   logic cmd_done_i = 1'h0, data_read_i = 1'h0;
   logic [7:0] drive_output_reg_data_i = 8'h04, rate_data_i = 8'h00, specify_data_i = 8'h5a;
   logic [7:0] id_track_i = 8'h05, internal_track_i = 8'h05;
   logic [4:0] lv = 5'h00;
   fdc_status_pkg::cmd_class_t cmd_class_i = '0;
   fdc_status_pkg::fdc_event_t event_i = '0;
   logic write_lock_pin_i, track_zero_pin_i, head_pick_pin_i;
   logic [1:0] unit_select_pin_i;
   logic [7:0] result_data_o, specify_o;
   logic result_phase_o, core_reset_o, powered_down_o, poll_enable_o, busy_o;
   logic drive_output_reg_reset_o;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] e2 [12] = '{8'h80, 8'h80, 8'h20, 8'h20, 8'h10, 8'h04, 8'h04, 8'h04,
      8'h01, 8'h01, 8'h00, 8'h00};
   logic [7:0] e3 [12] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h01, 8'h40, 8'h00};

   fdc_result_status fdc_result_status_inst (.*);
   drive_cable_model drive_cable_model_inst (.clk_i, .levels_i(lv),
      .write_lock_pin_o(write_lock_pin_i), .track_zero_pin_o(track_zero_pin_i),
      .head_pick_pin_o(head_pick_pin_i), .unit_select_pin_o(unit_select_pin_i));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         summarize;
      end
   end

   task automatic rd;
      data_read_i = 1'h1;
      @(negedge clk_i);
      data_read_i = 1'h0;
      repeat (2) @(negedge clk_i);
   endtask

   task automatic drive_output_wr(input logic [7:0] d);
      drive_output_reg_data_i = d;
      drive_output_reg_write_i = 1'h1;
      @(negedge clk_i);
      drive_output_reg_write_i = 1'h0;
      repeat (4) @(negedge clk_i);
   endtask

   // one command: start, one event pulse while busy, done, then three reads
   task automatic cmd(input logic wr, input logic [11:0] e, input logic [7:0] s2, s3);
      logic [7:0] s4;
      s4 = {1'h0, lv[4], 1'h1, lv[3], 1'h1, lv[2], lv[1:0]};
      repeat (4) @(negedge clk_i);
      cmd_class_i = {wr, !wr};
      cmd_start_i = 1'h1;
      @(negedge clk_i);
      cmd_start_i = 1'h0;
      @(negedge clk_i);
      event_i = fdc_status_pkg::fdc_event_t'(e);
      @(negedge clk_i);
      event_i = '0;
      cmd_done_i = 1'h1;
      @(negedge clk_i);
      cmd_done_i = 1'h0;
      for (int n = 0; n < 8 && result_phase_o !== 1'h1; n++) @(negedge clk_i);
      `CHK("second byte", s2, result_data_o)
      rd;
      `CHK("third byte", s3, result_data_o)
      rd;
      `CHK("fourth byte", s4, result_data_o)
      rd;
      `CHK("phase end", 1'h0, result_phase_o)
   endtask

   initial begin
      repeat (8) @(negedge clk_i);
      rst_i = 1'h0;
      @(negedge clk_i);
      `CHK("drive out reset", 1'h1, drive_output_reg_reset_o)
      `CHK("poll", 1'h1, poll_enable_o)
      `CHK("specify", 8'h00, specify_o)
      drive_output_wr(8'h00);
      `CHK("out of reset", 1'h0, core_reset_o)
      specify_write_i = 1'h1;
      configure_poll_off_i = 1'h1;
      configure_write_i = 1'h1;
      @(negedge clk_i);
      specify_write_i = 1'h0;
      configure_write_i = 1'h0;
      powerdown_req_i = 1'h1;
      @(negedge clk_i);
      powerdown_req_i = 1'h0;
      @(negedge clk_i);
      `CHK("poll off", 1'h0, poll_enable_o)
      `CHK("down", 1'h1, powered_down_o)
      rate_data_i = 8'h80;
      rate_write_i = 1'h1;
      @(negedge clk_i);
      rate_write_i = 1'h0;
      repeat (6) @(negedge clk_i);
      `CHK("woken", 1'h0, powered_down_o)
      `CHK("rate cleared", 1'h0, core_reset_o)
      `CHK("poll again", 1'h1, poll_enable_o)
      for (int i = 0; i < 12; i++) cmd(1'h0, 12'h800 >> i, e2[i], e3[i]);
      id_track_i = 8'h07;
      cmd(1'h0, 12'h001, 8'h00, 8'h10);
      id_track_i = 8'hff;
      cmd(1'h0, 12'h001, 8'h00, 8'h12);
      lv = 5'h15;
      cmd(1'h1, 12'h000, 8'h02, 8'h00);
      cmd(1'h0, 12'h000, 8'h00, 8'h00);
      lv = 5'h0a;
      cmd(1'h1, 12'h000, 8'h00, 8'h00);
      cmd_start_i = 1'h1;
      @(negedge clk_i);
      cmd_start_i = 1'h0;
      system_reset_pin_n_i = 1'h0;
      repeat (4) @(negedge clk_i);
      system_reset_pin_n_i = 1'h1;
      `CHK("aborted", 1'h0, busy_o)
      `CHK("pin drive out reset", 1'h1, drive_output_reg_reset_o)
      `CHK("specify kept", 8'h5a, specify_o)
      repeat (4) @(negedge clk_i);
      drive_output_wr(8'h00);
      drive_output_wr(8'h04);
      rate_data_i = 8'h80;
      rate_write_i = 1'h1;
      @(negedge clk_i);
      rate_write_i = 1'h0;
      repeat (8) @(negedge clk_i);
      `CHK("drive out precedence", 1'h1, core_reset_o)
      drive_output_wr(8'h00);
      cmd(1'h0, 12'h080, 8'h10, 8'h00);
      summarize;
   end
endmodule // tb_top
